// file: utlc_pkg.sv
// Package: constants, field layouts and types of the serial transmit and line-control block
package utlc_pkg;

	// ----------------------------------------------------------------
	// Clocks and baud generator
	// ----------------------------------------------------------------
	localparam int unsigned SYS_CLK_HZ  = 50_000_000;
	localparam int unsigned BAUD_REF_HZ = 5_068_800;

	typedef logic [12:0] utlc_div_t;

	// Reference clock edges per 16X tick, one entry per rate code 0 to 15
	localparam utlc_div_t BRG_DIV [16] = '{
		13'h18C0, 13'h1080, 13'h0B40, 13'h0933, 13'h0840, 13'h0420, 13'h0210, 13'h0108,
		13'h00B0, 13'h009E, 13'h0084, 13'h0058, 13'h0042, 13'h002C, 13'h0021, 13'h0010
	};

	// 16X ticks per half period of the 1X pin clock, minus one
	localparam logic [2:0] CLK_1X_HALF_LAST = 3'h7;

	// ----------------------------------------------------------------
	// Register map: byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [1:0]  IDX_DATA       = 2'h0;
	localparam logic [1:0]  IDX_STAT_SYN   = 2'h1;
	localparam logic [1:0]  IDX_MODE       = 2'h2;
	localparam logic [1:0]  IDX_CMD        = 2'h3;
	localparam logic [27:0] ADDR_HIGH_ZERO = 28'h000_0000;
	localparam logic [7:0]  REG_RESET      = 8'h00;
	localparam logic [23:0] RDATA_PAD      = 24'h00_0000;
	localparam logic [1:0]  SYN_PTR_LAST   = 2'h2;

	// ----------------------------------------------------------------
	// Field encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_SYNC      = 2'h0;
	localparam logic [1:0] MODE_ASYNC_1X  = 2'h1;
	localparam logic [1:0] MODE_ASYNC_16X = 2'h2;
	localparam logic [1:0] MODE_ASYNC_64X = 2'h3;
	localparam logic [1:0] STOP_ONE_HALF  = 2'h2;
	localparam logic [1:0] STOP_TWO       = 2'h3;
	localparam logic [7:0] FACTOR_1X      = 8'h01;
	localparam logic [7:0] FACTOR_16X     = 8'h10;
	localparam logic [7:0] FACTOR_64X     = 8'h40;
	localparam logic [2:0] CHAR_LEN_BASE  = 3'h4;

	// Synchroniser lanes
	localparam int IN_BAUD_REFERENCE_CLOCK = 0;
	localparam int IN_TXC   = 1;
	localparam int IN_DSR   = 2;
	localparam int IN_DCD   = 3;
	localparam int IN_CTS   = 4;
	localparam int IN_COUNT = 5;

	// ----------------------------------------------------------------
	// Register layouts
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       sync_count_select_bit;
		logic       transparency_select_bit;
		logic       parity_even;
		logic       parity_en;
		logic [1:0] char_len;
		logic [1:0] mode;
	} utlc_mode1_t;

	typedef struct packed {
		logic [1:0] unused;
		logic       tx_internal;
		logic       rx_internal;
		logic [3:0] rate;
	} utlc_mode2_t;

	typedef struct packed {
		logic [1:0] spare_hi;
		logic       rts;
		logic       spare_lo;
		logic       brk_dle;
		logic       rx_en;
		logic       dtr;
		logic       transmit_enable_bit;
	} utlc_cmd_t;

	typedef struct packed {
		logic       status_bit_seven;
		logic       status_bit_six;
		logic [2:0] spare;
		logic       empty_or_change;
		logic       receive_ready;
		logic       transmit_ready;
	} utlc_status_t;

	typedef enum logic [2:0] {
		TX_IDLE   = 3'b000,
		TX_START  = 3'b001,
		TX_DATA   = 3'b010,
		TX_PARITY = 3'b011,
		TX_STOP   = 3'b100
	} utlc_tx_state_t;

endpackage

// file: utlc_top.sv
// Module: serial transmitter, line control and AHB-Lite register slave
//
// Added by the designer: the address map and the AHB-Lite register port.
`timescale 1ns/100ps

// Notes on behaviour
// - External receive clock supplied at programmed multiple
// - Internal receive clock drives pin at 1X
// - External transmit clock: output changes on falling edges
// - Internal transmit clock drives pin at 1X
// - Mark is high; mark while transmitter disabled
// - Status bit seven shows inverted data-set-ready; change flagged
// - Status bit six shows inverted carrier; change flagged
// - Clear-to-send high stops after current character
// - Terminal-ready output is inverse of command bit one
// - Request-to-send output is inverse of command bit five
// - Ready set when space, transmitter enabled and clear-to-send low; cleared by holding write
// - Held character moves to shifter when idle
// - Async frame: start, data LSB first, parity, stops
// - Async underrun: mark line, assert transmitter empty
// - Send-break bit forces continuous low
// - Sync: line high until first character, then stream
// - Sync underrun: empty flag, fill with sync characters
// - Send-DLE bit sends DLE before held character
// - Sync register writes load FIRST_SYNC_CHAR, SECOND_SYNC_CHAR, DLE in turn
// - Mode accesses alternate mode one and mode two
// - Pointers wrap; reset by reset or command read
// - Master reset clears registers and stops activity
// - Sync fill chosen by mode one bits seven, six
module utlc_top (
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	input  wire logic        baud_reference_clock_in,
	input  wire logic        transmit_bit_clock_in,
	output logic             transmit_bit_clock_out,
	output logic             transmit_bit_clock_oe_out,
	input  wire logic        receive_bit_clock_in,
	output logic             receive_bit_clock_out,
	output logic             receive_bit_clock_oe_out,
	output logic             serial_data_out,
	input  wire logic        data_set_ready_n_in,
	input  wire logic        carrier_detect_n_in,
	input  wire logic        clear_to_send_n_in,
	output logic             data_terminal_ready_n_out,
	output logic             request_to_send_n_out,
	output logic             transmit_ready_n_out,
	output logic             empty_or_change_n_out
);
	import utlc_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [IN_COUNT-1:0] pin_raw;
	logic [IN_COUNT-1:0] sync_q1_reg;
	logic [IN_COUNT-1:0] sync_q2_reg;
	logic [IN_COUNT-1:0] sync_q3_reg;

	assign pin_raw = {clear_to_send_n_in, carrier_detect_n_in, data_set_ready_n_in,
		transmit_bit_clock_in, baud_reference_clock_in};

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			sync_q1_reg <= '1;
			sync_q2_reg <= '1;
			sync_q3_reg <= '1;
		end else begin
			sync_q1_reg <= pin_raw;
			sync_q2_reg <= sync_q1_reg;
			sync_q3_reg <= sync_q2_reg;
		end
	end

	logic baud_reference_clock_rise;
	logic txc_fall;
	logic line_change;
	logic cts_low;
	assign baud_reference_clock_rise  = sync_q2_reg[IN_BAUD_REFERENCE_CLOCK] && !sync_q3_reg[IN_BAUD_REFERENCE_CLOCK];
	assign txc_fall    = !sync_q2_reg[IN_TXC] && sync_q3_reg[IN_TXC];
	assign line_change = (sync_q2_reg[IN_DSR] ^ sync_q3_reg[IN_DSR]) ||
		(sync_q2_reg[IN_DCD] ^ sync_q3_reg[IN_DCD]);
	assign cts_low     = !sync_q2_reg[IN_CTS];

	// ----------------------------------------------------------------
	// AHB-Lite slave: writes take no wait state, reads take one
	// ----------------------------------------------------------------
	logic        ap_valid;
	logic        dp_wr_reg;
	logic        dp_rd_reg;
	logic        dp_map_reg;
	logic [1:0]  dp_idx_reg;
	logic        rd_done_reg;
	logic [31:0] hrdata_reg;
	logic        wr_fire;
	logic        rd_fire;
	utlc_cmd_t   wr_cmd_view;

	assign ap_valid    = hsel_in && htrans_in[1] && hready_in;
	assign wr_fire     = dp_wr_reg && dp_map_reg;
	assign rd_fire     = dp_rd_reg && !rd_done_reg && dp_map_reg;
	assign wr_cmd_view = utlc_cmd_t'(hwdata_in[7:0]);

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			dp_wr_reg  <= 1'b0;
			dp_rd_reg  <= 1'b0;
			dp_map_reg <= 1'b0;
			dp_idx_reg <= IDX_DATA;
		end else if (hready_in) begin
			dp_wr_reg  <= ap_valid && hwrite_in;
			dp_rd_reg  <= ap_valid && !hwrite_in;
			dp_map_reg <= haddr_in[31:4] == ADDR_HIGH_ZERO;
			dp_idx_reg <= haddr_in[3:2];
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			rd_done_reg <= 1'b0;
		end else if (dp_rd_reg && !rd_done_reg) begin
			rd_done_reg <= 1'b1;
		end else if (hready_in) begin
			rd_done_reg <= 1'b0;
		end
	end

	assign hreadyout_out = !(dp_rd_reg && !rd_done_reg);
	assign hresp_out     = 1'b0;
	assign hrdata_out    = hrdata_reg;

	// ----------------------------------------------------------------
	// Registers and access pointers
	// ----------------------------------------------------------------
	utlc_mode1_t  mode1_reg;
	utlc_mode2_t  mode2_reg;
	utlc_cmd_t    cmd_reg;
	utlc_status_t status_now;
	logic [7:0]   first_sync_char_reg;
	logic [7:0]   second_sync_char_reg;
	logic [7:0]   dle_reg;
	logic [7:0]   hold_reg;
	logic [1:0]   syn_ptr_reg;
	logic         mode_ptr_reg;
	logic         cmd_read;
	logic         mode_access;
	logic         tx_ready;

	assign cmd_read    = rd_fire && dp_idx_reg == IDX_CMD;
	assign mode_access = (rd_fire || wr_fire) && dp_idx_reg == IDX_MODE;

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			mode1_reg <= utlc_mode1_t'(REG_RESET);
			mode2_reg <= utlc_mode2_t'(REG_RESET);
			cmd_reg   <= utlc_cmd_t'(REG_RESET);
			first_sync_char_reg  <= REG_RESET;
			second_sync_char_reg  <= REG_RESET;
			dle_reg   <= REG_RESET;
			hold_reg  <= REG_RESET;
		end else if (wr_fire) begin
			unique case (dp_idx_reg)
				IDX_DATA: hold_reg <= hwdata_in[7:0];
				IDX_STAT_SYN: begin
					if (syn_ptr_reg == SYN_PTR_LAST) begin
						dle_reg <= hwdata_in[7:0];
					end else if (syn_ptr_reg[0]) begin
						second_sync_char_reg <= hwdata_in[7:0];
					end else begin
						first_sync_char_reg <= hwdata_in[7:0];
					end
				end
				IDX_MODE: begin
					if (mode_ptr_reg) begin
						mode2_reg <= utlc_mode2_t'(hwdata_in[7:0]);
					end else begin
						mode1_reg <= utlc_mode1_t'(hwdata_in[7:0]);
					end
				end
				IDX_CMD: cmd_reg <= wr_cmd_view;
			endcase
		end
	end

	// A command read realigns both pointers so software can recover a known order
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			syn_ptr_reg  <= 2'h0;
			mode_ptr_reg <= 1'b0;
		end else if (cmd_read) begin
			syn_ptr_reg  <= 2'h0;
			mode_ptr_reg <= 1'b0;
		end else begin
			if (wr_fire && dp_idx_reg == IDX_STAT_SYN) begin
				syn_ptr_reg <= (syn_ptr_reg == SYN_PTR_LAST) ? 2'h0 : syn_ptr_reg + 2'h1;
			end
			if (mode_access) begin
				mode_ptr_reg <= !mode_ptr_reg;
			end
		end
	end

	// Read data is captured in the wait cycle, so side effects happen once
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			hrdata_reg <= 32'h0000_0000;
		end else if (dp_rd_reg && !rd_done_reg) begin
			if (!dp_map_reg) begin
				hrdata_reg <= 32'h0000_0000;
			end else begin
				unique case (dp_idx_reg)
					IDX_DATA:     hrdata_reg <= {RDATA_PAD, REG_RESET};
					IDX_STAT_SYN: hrdata_reg <= {RDATA_PAD, status_now};
					IDX_MODE:     hrdata_reg <= {RDATA_PAD,
						mode_ptr_reg ? 8'(mode2_reg) : 8'(mode1_reg)};
					IDX_CMD:      hrdata_reg <= {RDATA_PAD, cmd_reg};
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Status flags and modem lines
	// ----------------------------------------------------------------
	logic hold_full_reg;
	logic tx_empty_reg;
	logic ds_change_reg;
	logic empty_set;
	logic take_hold;
	logic load;

	assign tx_ready = cmd_reg.transmit_enable_bit && cts_low && !hold_full_reg;

	always_comb begin
		status_now                  = utlc_status_t'(REG_RESET);
		status_now.transmit_ready   = tx_ready;
		status_now.empty_or_change  = tx_empty_reg || ds_change_reg;
		status_now.status_bit_six   = !sync_q2_reg[IN_DCD];
		status_now.status_bit_seven = !sync_q2_reg[IN_DSR];
	end

	// Set wins over clear on every flag below
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			hold_full_reg <= 1'b0;
			tx_empty_reg  <= 1'b0;
			ds_change_reg <= 1'b0;
		end else begin
			if (wr_fire && dp_idx_reg == IDX_DATA) begin
				hold_full_reg <= 1'b1;
			end else if (load && take_hold) begin
				hold_full_reg <= 1'b0;
			end
			if (empty_set) begin
				tx_empty_reg <= 1'b1;
			end else if (wr_fire && dp_idx_reg == IDX_DATA) begin
				tx_empty_reg <= 1'b0;
			end
			if (line_change) begin
				ds_change_reg <= 1'b1;
			end else if (rd_fire && dp_idx_reg == IDX_STAT_SYN) begin
				ds_change_reg <= 1'b0;
			end
		end
	end

	assign data_terminal_ready_n_out = !cmd_reg.dtr;
	assign request_to_send_n_out     = !cmd_reg.rts;
	assign transmit_ready_n_out      = !tx_ready;
	assign empty_or_change_n_out     = !(tx_empty_reg || ds_change_reg);

	// ----------------------------------------------------------------
	// Baud generator and bit clock pins
	// ----------------------------------------------------------------
	utlc_div_t  brg_cnt_reg;
	logic       brg_tick;
	logic [2:0] half_cnt_reg;
	logic       clk_1x_reg;

	// A count already past a new, smaller divisor ends at once instead of wrapping the counter
	assign brg_tick = baud_reference_clock_rise && (brg_cnt_reg >= BRG_DIV[mode2_reg.rate] - 13'h0001);

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			brg_cnt_reg  <= '0;
			half_cnt_reg <= 3'h0;
			clk_1x_reg   <= 1'b0;
		end else begin
			if (brg_tick) begin
				brg_cnt_reg <= '0;
			end else if (baud_reference_clock_rise) begin
				brg_cnt_reg <= brg_cnt_reg + 13'h0001;
			end
			if (brg_tick) begin
				half_cnt_reg <= half_cnt_reg + 3'h1;
				if (half_cnt_reg == CLK_1X_HALF_LAST) begin
					clk_1x_reg <= !clk_1x_reg;
				end
			end
		end
	end

	assign transmit_bit_clock_out    = clk_1x_reg;
	assign transmit_bit_clock_oe_out = mode2_reg.tx_internal;
	assign receive_bit_clock_out     = clk_1x_reg;
	assign receive_bit_clock_oe_out  = mode2_reg.rx_internal;

	// ----------------------------------------------------------------
	// Transmit engine
	// ----------------------------------------------------------------
	utlc_tx_state_t state_reg;
	logic [7:0]     shift_reg;
	logic [7:0]     sub_cnt_reg;
	logic [2:0]     bit_cnt_reg;
	logic           par_reg;
	logic           sync_active_reg;
	logic           dle_done_reg;
	logic           fill_second_reg;
	logic           line_reg;
	logic           sync_mode;
	logic           go;
	logic           tx_tick;
	logic [7:0]     factor;
	logic [7:0]     bit_len;
	logic           bit_end;
	logic           bit_last;
	logic           char_done;
	logic           can_data;
	logic           use_dle;
	logic           next_fill;
	logic [7:0]     next_char;
	logic           line_bit;

	assign sync_mode = mode1_reg.mode == MODE_SYNC;
	assign go        = cmd_reg.transmit_enable_bit && cts_low;
	// Bit steps follow the falling edge of an external clock
	assign tx_tick   = mode2_reg.tx_internal ? brg_tick : txc_fall;
	assign bit_last  = bit_cnt_reg == {1'b0, mode1_reg.char_len} + CHAR_LEN_BASE;
	assign can_data  = hold_full_reg && go;

	always_comb begin
		if (mode2_reg.tx_internal || mode1_reg.mode == MODE_ASYNC_16X) begin
			factor = FACTOR_16X;
		end else if (mode1_reg.mode == MODE_ASYNC_64X) begin
			factor = FACTOR_64X;
		end else begin
			factor = FACTOR_1X;
		end
		bit_len = factor;
		if (state_reg == TX_STOP) begin
			if (mode1_reg.sync_count_select_bit && mode1_reg.transparency_select_bit) begin
				bit_len = 8'(factor << 1);
			end else if (mode1_reg[7:6] == STOP_ONE_HALF && factor != FACTOR_1X) begin
				bit_len = factor + (factor >> 1);
			end
		end
		bit_end = tx_tick && (sub_cnt_reg == bit_len - 8'h01);
		unique case (state_reg)
			TX_DATA:   char_done = bit_end && bit_last && !mode1_reg.parity_en && sync_mode;
			TX_PARITY: char_done = bit_end && sync_mode;
			TX_STOP:   char_done = bit_end;
			default:   char_done = 1'b0;
		endcase
		// Fill only keeps a started sync stream alive
		load = (state_reg == TX_IDLE && tx_tick && can_data) ||
			(char_done && (can_data || (sync_mode && sync_active_reg && go)));
		empty_set = char_done && !can_data;
	end

	always_comb begin
		take_hold = 1'b0;
		use_dle   = 1'b0;
		next_fill = 1'b0;
		next_char = first_sync_char_reg;
		if (can_data) begin
			if (sync_mode && cmd_reg.brk_dle && !dle_done_reg) begin
				use_dle   = 1'b1;
				next_char = dle_reg;
			end else begin
				take_hold = 1'b1;
				next_char = hold_reg;
			end
		end else begin
			next_fill = 1'b1;
			if (mode1_reg.transparency_select_bit) begin
				next_char = fill_second_reg ? first_sync_char_reg : dle_reg;
			end else if (!mode1_reg.sync_count_select_bit && fill_second_reg) begin
				next_char = second_sync_char_reg;
			end
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg       <= TX_IDLE;
			shift_reg       <= REG_RESET;
			sub_cnt_reg     <= 8'h00;
			bit_cnt_reg     <= 3'h0;
			par_reg         <= 1'b0;
			sync_active_reg <= 1'b0;
			dle_done_reg    <= 1'b0;
			fill_second_reg <= 1'b0;
		end else if (!cmd_reg.transmit_enable_bit) begin
			state_reg       <= TX_IDLE;
			sub_cnt_reg     <= 8'h00;
			sync_active_reg <= 1'b0;
			dle_done_reg    <= 1'b0;
			fill_second_reg <= 1'b0;
		end else if (load) begin
			shift_reg       <= next_char;
			bit_cnt_reg     <= 3'h0;
			sub_cnt_reg     <= 8'h00;
			par_reg         <= !mode1_reg.parity_even;
			state_reg       <= sync_mode ? TX_DATA : TX_START;
			sync_active_reg <= sync_mode;
			dle_done_reg    <= use_dle;
			fill_second_reg <= next_fill && !fill_second_reg && !(mode1_reg.sync_count_select_bit
				&& !mode1_reg.transparency_select_bit);
		end else if (state_reg != TX_IDLE && tx_tick) begin
			if (bit_end) begin
				sub_cnt_reg <= 8'h00;
				unique case (state_reg)
					TX_START: state_reg <= TX_DATA;
					TX_DATA: begin
						shift_reg   <= shift_reg >> 1;
						par_reg     <= par_reg ^ shift_reg[0];
						bit_cnt_reg <= bit_cnt_reg + 3'h1;
						if (bit_last) begin
							state_reg <= mode1_reg.parity_en ? TX_PARITY :
								(sync_mode ? TX_IDLE : TX_STOP);
						end
					end
					TX_PARITY: state_reg <= sync_mode ? TX_IDLE : TX_STOP;
					default:   state_reg <= TX_IDLE;
				endcase
			end else begin
				sub_cnt_reg <= sub_cnt_reg + 8'h01;
			end
		end
	end

	always_comb begin
		unique case (state_reg)
			TX_START:  line_bit = 1'b0;
			TX_DATA:   line_bit = shift_reg[0];
			TX_PARITY: line_bit = par_reg;
			default:   line_bit = 1'b1;
		endcase
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			line_reg <= 1'b1;
		end else if (!cmd_reg.transmit_enable_bit) begin
			line_reg <= 1'b1;
		end else if (cmd_reg.brk_dle && !sync_mode) begin
			line_reg <= 1'b0;
		end else begin
			line_reg <= line_bit;
		end
	end

	assign serial_data_out = line_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	utlc_status_t rd_status_view;
	assign rd_status_view = utlc_status_t'(hrdata_out[7:0]);

	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	property p_dtr;
		(wr_fire && dp_idx_reg == IDX_CMD) |=> data_terminal_ready_n_out == !$past(wr_cmd_view.dtr);
	endproperty
	a_dtr: assert property (p_dtr) else $error("Terminal-ready does not follow command");

	property p_rts;
		(wr_fire && dp_idx_reg == IDX_CMD) |=> request_to_send_n_out == !$past(wr_cmd_view.rts);
	endproperty
	a_rts: assert property (p_rts) else $error("Request-to-send does not follow command");

	property p_mark_off;
		!cmd_reg.transmit_enable_bit |=> serial_data_out;
	endproperty
	a_mark_off: assert property (p_mark_off) else $error("Line not at mark when disabled");

	property p_break;
		(cmd_reg.transmit_enable_bit && cmd_reg.brk_dle && !sync_mode) |=> !serial_data_out;
	endproperty
	a_break: assert property (p_break) else $error("Break not held low");

	property p_ready_clear;
		(wr_fire && dp_idx_reg == IDX_DATA) |=> transmit_ready_n_out;
	endproperty
	a_ready_clear: assert property (p_ready_clear) else $error("Ready stays after load");

	property p_change;
		line_change |=> !empty_or_change_n_out;
	endproperty
	a_change: assert property (p_change) else $error("Line change not flagged");

	property p_status_dsr;
		(rd_fire && dp_idx_reg == IDX_STAT_SYN) |=>
			rd_status_view.status_bit_seven == !$past(sync_q2_reg[IN_DSR]);
	endproperty
	a_status_dsr: assert property (p_status_dsr) else $error("Status seven wrong");

	property p_ptr_reset;
		cmd_read |=> (syn_ptr_reg == 2'h0) && !mode_ptr_reg;
	endproperty
	a_ptr_reset: assert property (p_ptr_reset) else $error("Pointers not reset");

	property p_mode_ptr;
		(mode_access && !cmd_read) |=> mode_ptr_reg != $past(mode_ptr_reg);
	endproperty
	a_mode_ptr: assert property (p_mode_ptr) else $error("Mode pointer did not alternate");

	property p_start_bit;
		(state_reg == TX_START && cmd_reg.transmit_enable_bit) |=> !serial_data_out;
	endproperty
	a_start_bit: assert property (p_start_bit) else $error("Start bit not low");

	property p_sync_wait;
		(sync_mode && !sync_active_reg && cmd_reg.transmit_enable_bit) |=> serial_data_out;
	endproperty
	a_sync_wait: assert property (p_sync_wait) else $error("Sync line not high");

	property p_empty;
		empty_set |=> !empty_or_change_n_out;
	endproperty
	a_empty: assert property (p_empty) else $error("Underrun not flagged");

endmodule

// file: utlc_remote_model.sv
// Remote terminal model: external bit clock and async frame decoder
`timescale 1ns/100ps
module utlc_remote_model (
	input  wire logic run_in,
	input  wire logic line_in,
	output logic      clk_out,
	output logic [7:0] byte_out,
	output int        count_out
);
	int         bit_idx = 0;
	logic [7:0] shift_reg = 8'h00;
	initial clk_out = 1'b1;
	initial count_out = 0;
	// Clock stands high while run_in is low so no stray falling edge appears
	always #80 clk_out = run_in ? ~clk_out : 1'b1;
	// Line moves after each fall, so the next fall sees a settled bit
	always @(negedge clk_out) begin
		if (bit_idx == 0) begin
			if (line_in === 1'b0) bit_idx <= 1;
		end else if (bit_idx <= 8) begin
			shift_reg <= {line_in, shift_reg[7:1]};
			bit_idx <= bit_idx + 1;
		end else begin
			byte_out <= shift_reg;
			count_out <= count_out + 1;
			bit_idx <= 0;
		end
	end
endmodule

// file: tb.sv
// Testbench: registers, async traffic, break and modem status
`timescale 1ns/100ps
module tb;
	logic        clk_sys_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        hsel = 1'b0, hwrite = 1'b0, baud_reference_clock = 1'b0, run = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
	logic        dsr_n = 1'b0, dcd_n = 1'b0, cts_n = 1'b0;
	logic        hready, hresp, txc_out, txc_oe, txc_pin, m_clk, txd, dtr_n, rts_n, rdy_n, emt_n;
	logic [7:0]  rx_byte, d;
	logic        rxc_out, rxc_oe;
	int          rx_count, err_count = 0, n_compared = 0, cycles = 0;
	logic [7:0]  exp_q[$];

	initial forever #10 clk_sys_in = ~clk_sys_in;
	always #99 baud_reference_clock = ~baud_reference_clock;
	assign txc_pin = txc_oe ? txc_out : m_clk;

	utlc_top u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
		.baud_reference_clock_in(baud_reference_clock), .transmit_bit_clock_in(txc_pin),
		.transmit_bit_clock_out(txc_out), .transmit_bit_clock_oe_out(txc_oe),
		.receive_bit_clock_in(1'b0), .receive_bit_clock_out(rxc_out), .receive_bit_clock_oe_out(rxc_oe),
		.serial_data_out(txd), .data_set_ready_n_in(dsr_n), .carrier_detect_n_in(dcd_n),
		.clear_to_send_n_in(cts_n), .data_terminal_ready_n_out(dtr_n),
		.request_to_send_n_out(rts_n), .transmit_ready_n_out(rdy_n),
		.empty_or_change_n_out(emt_n));
	utlc_remote_model u_remote (.run_in(run), .line_in(txd), .clk_out(m_clk),
		.byte_out(rx_byte), .count_out(rx_count));

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task stop_test;
		if (err_count == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task bus(input logic wr, input logic [7:0] a, input logic [7:0] wd);
		@(posedge clk_sys_in);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		do @(posedge clk_sys_in); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h00_0000, wd};
		do @(posedge clk_sys_in); while (hready !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	// Hang guard: far above the few thousand cycles the run needs
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 60000) begin
			err_count++;
			stop_test;
		end
	end

	always @(rx_count) #1 chk("rx_byte", {24'h0, exp_q.pop_front()}, {24'h0, rx_byte});

	initial begin
		rd = $urandom(32'hff155019);
		repeat (16) @(posedge clk_sys_in);
		chk("txd", 1, txd);
		chk("dtr_n", 1, dtr_n);
		rst_in <= 1'b0;
		repeat (8) @(posedge clk_sys_in);
		bus(0, 8'h04, 8'h00);
		chk("status", 32'h0000_00C4, rd);
		@(posedge clk_sys_in);
		chk("emt_n", 1, emt_n);
		bus(1, 8'h08, 8'h4D);
		bus(1, 8'h08, 8'h00);
		bus(1, 8'h0C, 8'h23);
		bus(0, 8'h0C, 8'h00);
		chk("cmd", 32'h23, rd);
		bus(0, 8'h08, 8'h00);
		chk("mode1", 32'h4D, rd);
		bus(0, 8'h08, 8'h00);
		chk("mode2", 32'h0, rd);
		bus(0, 8'h08, 8'h00);
		chk("mode1", 32'h4D, rd);
		bus(0, 8'h0C, 8'h00);
		bus(0, 8'h08, 8'h00);
		chk("mode1 after cmd read", 32'h4D, rd);
		bus(0, 8'h40, 8'h00);
		chk("unmapped", 32'h0, rd);
		chk("dtr_n", 0, dtr_n);
		chk("rts_n", 0, rts_n);
		run <= 1'b1;
		repeat (4) begin
			// Let the previous holding write settle before ready is looked at again
			@(posedge clk_sys_in);
			while (rdy_n !== 1'b0) @(posedge clk_sys_in);
			d = 8'($urandom);
			exp_q.push_back(d);
			bus(1, 8'h00, d);
		end
		while (rx_count < 4) @(posedge clk_sys_in);
		// Stop the remote clock so the break is not decoded as a character
		run <= 1'b0;
		repeat (200) @(posedge clk_sys_in);
		chk("emt_n", 0, emt_n);
		chk("txd", 1, txd);
		bus(1, 8'h0C, 8'h2B);
		repeat (100) @(posedge clk_sys_in);
		chk("txd", 0, txd);
		bus(1, 8'h0C, 8'h00);
		repeat (100) @(posedge clk_sys_in);
		chk("txd", 1, txd);
		dsr_n <= 1'b1;
		repeat (10) @(posedge clk_sys_in);
		bus(0, 8'h04, 8'h00);
		chk("status", 32'h0000_0044, rd);
		// Sync: all-ones characters keep the remote decoder quiet
		bus(0, 8'h0C, 8'h00);
		repeat (3) bus(1, 8'h04, 8'hFF);
		bus(1, 8'h08, 8'h80);
		bus(1, 8'h08, 8'h00);
		bus(1, 8'h0C, 8'h01);
		repeat (20) @(posedge clk_sys_in);
		chk("rdy_n", 0, rdy_n);
		chk("txd", 1, txd);
		bus(1, 8'h00, 8'hFF);
		@(posedge clk_sys_in);
		chk("emt_n", 1, emt_n);
		run <= 1'b1;
		repeat (300) @(posedge clk_sys_in);
		chk("emt_n", 0, emt_n);
		chk("txd", 1, txd);
		run <= 1'b0;
		// Internal bit clocks drive both pins
		bus(1, 8'h08, 8'h4D);
		bus(1, 8'h08, 8'h3F);
		@(posedge clk_sys_in);
		chk("txc_oe", 1, txc_oe);
		chk("rxc_oe", 1, rxc_oe);
		d = {7'h00, txc_out};
		repeat (1400) if (txc_out === d[0]) @(posedge clk_sys_in);
		chk("txc_out", {31'h0, !d[0]}, {31'h0, txc_out});
		chk("rxc_out", {31'h0, txc_out}, {31'h0, rxc_out});
		stop_test;
	end
endmodule
